// [acr_checker.sv]
// Concurrent assertions watching the ports of the control-bus register bank.
`default_nettype none
module acr_checker #(
  parameter logic [14:0] FW_VERSION = 15'h0001
) (
  input wire logic         CLK_SYS,
  input wire logic         RESET,
  input wire logic [15:0]  CB_ADDR,
  input wire logic         CB_WR,
  input wire logic         CB_RD,
  input wire logic [15:0]  CB_WDATA,
  input wire logic [15:0]  CB_RDATA,
  input wire logic         CB_RVALID,
  input wire logic [191:0] LIVE_SAMPLES,
  input wire logic [191:0] PLAYBACK_SAMPLES,
  input wire logic [191:0] PROC_SAMPLES,
  input wire logic [3:0]   FMT_START,
  input wire logic [1:0]   PULSE_COUNT,
  input wire logic [8:0]   WINDOW_LENGTH,
  input wire logic [8:0]   REPORT_LENGTH,
  input wire logic         DISCARD_LAST,
  input wire logic [15:0]  CONV_SEL,
  input wire logic         CONV_REQ,
  input wire logic         CONV_RNW,
  input wire logic [7:0]   CONV_ADDR,
  input wire logic [7:0]   CONV_WDATA,
  input wire logic         CONV_ACK
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] cfg_q, msk_q, ctl_q, dat_q;
  logic [8:0]  win_q;

  // Shadow copies let the outputs be judged only once a setting has been stable for a cycle.
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      cfg_q <= 16'h0000;
      msk_q <= 16'h0000;
      ctl_q <= 16'h0000;
      dat_q <= 16'h0000;
      win_q <= 9'h006;
    end else if (CB_WR) begin
      case (CB_ADDR)
        16'h0003: cfg_q <= CB_WDATA;
        16'h0004: msk_q <= CB_WDATA;
        16'h0005: ctl_q <= CB_WDATA;
        16'h0006: dat_q <= CB_WDATA;
        16'h0007: win_q <= (CB_WDATA[8:0] < 9'h006) ? 9'h006 : CB_WDATA[8:0];
        default: ;
      endcase
    end
  end

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RESET);

  sequence s_go;
    CB_WR && CB_ADDR == 16'h0005 && CB_WDATA[7] && !ctl_q[7] && !CONV_REQ && CONV_SEL == 16'h0000;
  endsequence
  sequence s_wait;
    CONV_REQ && !CONV_ACK;
  endsequence

  a_rvalid_pulse: assert property (CB_RVALID == $past(CB_RD))
    else $error("read answer not one cycle after the strobe");
  a_unmapped_zero: assert property (
    CB_RD && CB_ADDR > 16'h0009 |=> CB_RDATA == 16'h0000) else $error("unmapped read not zero");
  a_version_code: assert property (
    CB_RD && CB_ADDR == 16'h0000 |=> CB_RDATA[14:0] == FW_VERSION) else $error("version code wrong");
  a_pulse_count: assert property (
    $stable(cfg_q) |-> PULSE_COUNT == cfg_q[5:4]) else $error("pulse count differs from config");
  a_window_len: assert property (
    $stable(win_q) |-> WINDOW_LENGTH == win_q && REPORT_LENGTH == win_q + {8'h00, win_q[0]}
      && DISCARD_LAST == win_q[0]) else $error("window length outputs wrong");
  for (genvar n = 0; n < 16; n++) begin : g_ch
    a_sample_select: assert property (
      // The first cycle after reset still shows the cleared output, not the source.
      !$past(RESET) && $stable(cfg_q[7]) && $stable(msk_q[n]) |->
        PROC_SAMPLES[12*n +: 12] == (msk_q[n] ? 12'h000 :
        cfg_q[7] ? $past(PLAYBACK_SAMPLES[12*n +: 12]) : $past(LIVE_SAMPLES[12*n +: 12])))
      else $error("processed sample source or mask wrong");
  end
  a_fmt_mode: assert property (
    FMT_START != 4'h0 |-> ((cfg_q[2:0] == 3'h7) ? (FMT_START == 4'h1 || FMT_START == 4'h8)
      : (!cfg_q[2] && FMT_START == 4'h1 << cfg_q[1:0]))) else $error("formatter launch does not match mode");
  a_conv_start: assert property (
    s_go |-> ##3 CONV_REQ && CONV_SEL == ($past(CB_WDATA[6], 3) ? 16'hFFFF : 16'h0001 << $past(CB_WDATA[3:0], 3)))
    else $error("converter access not started on select");
  a_req_hold: assert property (
    s_wait |=> CONV_REQ) else $error("request dropped before acknowledge");
  a_req_release: assert property (
    CONV_REQ && CONV_ACK |=> !CONV_REQ ##1 CONV_SEL == 16'h0000) else $error("access not ended after acknowledge");
  a_conv_fields: assert property (
    $rose(CONV_REQ) |-> CONV_ADDR == dat_q[15:8] && CONV_WDATA == dat_q[7:0] && CONV_RNW == ctl_q[5])
    else $error("converter access fields wrong");
endmodule // acr_checker

bind acr_register_bank acr_checker #(.FW_VERSION(FW_VERSION)) u_chk (
  .CLK_SYS(CLK_SYS), .RESET(RESET), .CB_ADDR(CB_ADDR), .CB_WR(CB_WR), .CB_RD(CB_RD), .CB_WDATA(CB_WDATA),
  .CB_RDATA(CB_RDATA), .CB_RVALID(CB_RVALID), .LIVE_SAMPLES(LIVE_SAMPLES), .PLAYBACK_SAMPLES(PLAYBACK_SAMPLES),
  .PROC_SAMPLES(PROC_SAMPLES), .FMT_START(FMT_START), .PULSE_COUNT(PULSE_COUNT), .WINDOW_LENGTH(WINDOW_LENGTH),
  .REPORT_LENGTH(REPORT_LENGTH), .DISCARD_LAST(DISCARD_LAST), .CONV_SEL(CONV_SEL), .CONV_REQ(CONV_REQ),
  .CONV_RNW(CONV_RNW), .CONV_ADDR(CONV_ADDR), .CONV_WDATA(CONV_WDATA), .CONV_ACK(CONV_ACK));
`default_nettype wire

// [acr_conv_if.sv]
// Interface between the register bank and the converter access sequencer.
`default_nettype none
interface acr_conv_if;
  logic                   start;
  logic                   all_chips;
  logic [3:0]             chip;
  logic                   rnw;
  logic [7:0]             reg_addr;
  logic [7:0]             wdata;
  logic                   busy;
  logic                   rd_done;
  logic [7:0]             rdata;
  logic [15:0]            conv_sel;
  logic                   conv_req;
  logic                   conv_rnw;
  logic [7:0]             conv_addr;
  logic [7:0]             conv_wdata;

  modport bank (output start, all_chips, chip, rnw, reg_addr, wdata,
                input busy, rd_done, rdata, conv_sel, conv_req, conv_rnw, conv_addr, conv_wdata);
  modport seq  (input start, all_chips, chip, rnw, reg_addr, wdata,
                output busy, rd_done, rdata, conv_sel, conv_req, conv_rnw, conv_addr, conv_wdata);
endinterface : acr_conv_if
`default_nettype wire

// [acr_conv_model.sv]
// Behavioural model of the converter chips answering register accesses.
`default_nettype none
module acr_conv_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       req,
  input  wire logic       rnw,
  input  wire logic [7:0] addr,
  input  wire logic [3:0] dly,
  output var  logic       ack,
  output var  logic [7:0] rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_reg;

  // Outside an answer the read lines toggle, so stale data is never mistaken for a result.
  always_ff @(posedge clk) begin
    if (rst || !req || ack) begin
      cnt_reg <= 4'h0;
      ack <= 1'b0;
      rdata <= rst ? 8'h5A : ~rdata;
    end else if (cnt_reg == dly) begin
      ack <= 1'b1;
      rdata <= rnw ? ~addr : ~rdata;
    end else begin
      cnt_reg <= cnt_reg + 4'h1;
      rdata <= ~rdata;
    end
  end
endmodule // acr_conv_model
`default_nettype wire

// [acr_conv_seq.sv]
// Sequencer that carries one register access to the external converter chips.
`default_nettype none
module acr_conv_seq (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic conv_ack,
  input  wire logic [7:0] conv_rdata,
  acr_conv_if.seq   cif
);
  acr_pkg::acr_seq_state_t state_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg      <= acr_pkg::SEQ_IDLE;
      cif.busy       <= 1'b0;
      cif.rd_done    <= 1'b0;
      cif.rdata      <= 8'h00;
      cif.conv_sel   <= acr_pkg::RST_ZERO16;
      cif.conv_req   <= 1'b0;
      cif.conv_rnw   <= 1'b0;
      cif.conv_addr  <= 8'h00;
      cif.conv_wdata <= 8'h00;
    end else begin
      cif.rd_done <= 1'b0;
      case (state_reg)
        acr_pkg::SEQ_IDLE: begin
          if (cif.start) begin
            // Parameters are frozen for the whole access so a bus write cannot tear it.
            cif.conv_sel   <= cif.all_chips ? 16'hFFFF : (16'h0001 << cif.chip);
            cif.conv_rnw   <= cif.rnw;
            cif.conv_addr  <= cif.reg_addr;
            cif.conv_wdata <= cif.wdata;
            cif.conv_req   <= 1'b1;
            cif.busy       <= 1'b1;
            state_reg      <= acr_pkg::SEQ_REQ;
          end
        end
        acr_pkg::SEQ_REQ: begin
          if (conv_ack) begin
            cif.conv_req <= 1'b0;
            if (cif.conv_rnw) begin
              cif.rdata   <= conv_rdata;
              cif.rd_done <= 1'b1;
            end
            state_reg <= acr_pkg::SEQ_DONE;
          end
        end
        acr_pkg::SEQ_DONE: begin
          cif.conv_sel <= acr_pkg::RST_ZERO16;
          cif.busy     <= 1'b0;
          state_reg    <= acr_pkg::SEQ_IDLE;
        end
        default: state_reg <= acr_pkg::SEQ_IDLE;
      endcase
    end
  end
endmodule : acr_conv_seq
`default_nettype wire

// [acr_pkg.sv]
// Package with the register map, field layouts and encodings of the control-bus register bank.
`default_nettype none
package acr_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int NUM_CH = 16;
  localparam int SMP_W  = 12;
  localparam int CH_W   = 4;

  // Register offsets on the control bus.
  localparam logic [15:0] OFS_VERSION_AND_READY   = 16'h0000;
  localparam logic [15:0] OFS_TRIGGER_COUNT       = 16'h0001;
  localparam logic [15:0] OFS_DEBUG_MONITOR       = 16'h0002;
  localparam logic [15:0] OFS_PROCESSING_CONFIG   = 16'h0003;
  localparam logic [15:0] OFS_CHANNEL_ZERO_MASK   = 16'h0004;
  localparam logic [15:0] OFS_CONV_ACCESS_CONTROL = 16'h0005;
  localparam logic [15:0] OFS_CONV_ACCESS_DATA    = 16'h0006;
  localparam logic [15:0] OFS_WINDOW_LENGTH       = 16'h0007;
  localparam logic [15:0] OFS_LOOKBACK_DEPTH      = 16'h0008;
  localparam logic [15:0] OFS_PRE_TRIGGER_COUNT   = 16'h0009;

  // Field positions.
  localparam int VER_READY_BIT   = 15;
  localparam int VER_CODE_W      = 15;
  localparam int CFG_MODE_LSB    = 0;
  localparam int CFG_MODE_W      = 3;
  localparam int CFG_RUN_BIT     = 3;
  localparam int CFG_PULSES_LSB  = 4;
  localparam int CFG_PULSES_W    = 2;
  localparam int CFG_PLAYBACK_BIT = 7;
  localparam int CFG_MONSEL_LSB  = 8;
  localparam int CAC_CHIP_LSB    = 0;
  localparam int CAC_RESET_BIT   = 4;
  localparam int CAC_RNW_BIT     = 5;
  localparam int CAC_ALL_BIT     = 6;
  localparam int CAC_GO_BIT      = 7;
  localparam int CAD_REG_LSB     = 8;
  localparam int CAD_DATA_LSB    = 0;
  localparam int CAD_BYTE_W      = 8;

  localparam int WIN_W  = 9;
  localparam int LOOK_W = 11;
  localparam int PRE_W  = 12;

  // Reset values and minimum settings.
  localparam logic [15:0]     RST_ZERO16 = 16'h0000;
  localparam logic [WIN_W-1:0] WIN_MIN    = 9'h006;
  localparam logic [PRE_W-1:0] PRE_MIN    = 12'h002;

  // Mode field encodings.
  localparam logic [2:0] MODE_RAW      = 3'h0;
  localparam logic [2:0] MODE_PULSE    = 3'h1;
  localparam logic [2:0] MODE_INTEGRAL = 3'h2;
  localparam logic [2:0] MODE_TIMING   = 3'h3;
  localparam logic [2:0] MODE_RAW_THEN_TIMING = 3'h7;

  // Launch lines of the per-mode formatters, one-hot.
  localparam int FMT_RAW_IDX      = 0;
  localparam int FMT_PULSE_IDX    = 1;
  localparam int FMT_INTEGRAL_IDX = 2;
  localparam int FMT_TIMING_IDX   = 3;
  localparam int FMT_N            = 4;

  typedef enum {FMT_IDLE, FMT_LAUNCH, FMT_WAIT, FMT_LAUNCH2, FMT_WAIT2} acr_fmt_state_t;
  typedef enum {SEQ_IDLE, SEQ_REQ, SEQ_DONE} acr_seq_state_t;
endpackage : acr_pkg
`default_nettype wire

// [acr_register_bank.sv]
// Control-bus register bank with channel masking, monitor, converter access and formatter dispatch.
`default_nettype none
module acr_register_bank #(
  parameter logic [14:0] FW_VERSION = 15'h0001  // Arbitrary value.
) (
  input  wire logic        CLK_SYS,
  input  wire logic        RESET,
  input  wire logic [15:0] CB_ADDR,
  input  wire logic        CB_WR,
  input  wire logic        CB_RD,
  input  wire logic [15:0] CB_WDATA,
  output var  logic [15:0] CB_RDATA,
  output var  logic        CB_RVALID,
  input  wire logic [191:0] LIVE_SAMPLES,
  input  wire logic [191:0] PLAYBACK_SAMPLES,
  output var  logic [191:0] PROC_SAMPLES,
  input  wire logic        TRIGGER,
  input  wire logic        EVENT_READY,
  input  wire logic        FMT_DONE,
  output var  logic [3:0]  FMT_START,
  output var  logic [1:0]  PULSE_COUNT,
  output var  logic [8:0]  WINDOW_LENGTH,
  output var  logic [8:0]  REPORT_LENGTH,
  output var  logic        DISCARD_LAST,
  output var  logic [10:0] LOOKBACK_DEPTH,
  output var  logic [11:0] PRE_TRIGGER_COUNT,
  output var  logic        CONV_RESET,
  output var  logic [15:0] CONV_SEL,
  output var  logic        CONV_REQ,
  output var  logic        CONV_RNW,
  output var  logic [7:0]  CONV_ADDR,
  output var  logic [7:0]  CONV_WDATA,
  input  wire logic        CONV_ACK,
  input  wire logic [7:0]  CONV_RDATA
);
  logic [15:0] trigger_count_reg;
  logic [15:0] processing_config_reg;
  logic [15:0] channel_zero_mask_reg;
  logic [15:0] converter_access_control_reg;
  logic [15:0] converter_access_data_reg;
  logic [8:0]  window_length_reg;
  logic [10:0] lookback_depth_reg;
  logic [11:0] pre_trigger_count_reg;
  logic [15:0] debug_monitor_reg;
  logic        go_prev_reg;
  logic        conv_start_reg;
  logic [15:0] rdata_next;
  logic [2:0]  mode;
  logic [3:0]  mon_sel;
  logic [191:0] src_samples;

  acr_pkg::acr_fmt_state_t fmt_state_reg;

  acr_conv_if cif ();

  assign mode    = processing_config_reg[acr_pkg::CFG_MODE_LSB +: acr_pkg::CFG_MODE_W];
  assign mon_sel = processing_config_reg[acr_pkg::CFG_MONSEL_LSB +: acr_pkg::CH_W];

  // Writes to configuration registers.
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      processing_config_reg        <= acr_pkg::RST_ZERO16;
      channel_zero_mask_reg        <= acr_pkg::RST_ZERO16;
      converter_access_control_reg <= acr_pkg::RST_ZERO16;
      window_length_reg            <= acr_pkg::WIN_MIN;
      lookback_depth_reg           <= 11'h000;
      pre_trigger_count_reg        <= acr_pkg::PRE_MIN;
    end else if (CB_WR) begin
      case (CB_ADDR)
        acr_pkg::OFS_PROCESSING_CONFIG:   processing_config_reg <= CB_WDATA;
        acr_pkg::OFS_CHANNEL_ZERO_MASK:   channel_zero_mask_reg <= CB_WDATA;
        acr_pkg::OFS_CONV_ACCESS_CONTROL: converter_access_control_reg <= CB_WDATA;
        acr_pkg::OFS_WINDOW_LENGTH: begin
          // Settings below the minimum are raised to it rather than left unusable.
          if (CB_WDATA[acr_pkg::WIN_W-1:0] < acr_pkg::WIN_MIN) begin
            window_length_reg <= acr_pkg::WIN_MIN;
          end else begin
            window_length_reg <= CB_WDATA[acr_pkg::WIN_W-1:0];
          end
        end
        acr_pkg::OFS_LOOKBACK_DEPTH: lookback_depth_reg <= CB_WDATA[acr_pkg::LOOK_W-1:0];
        acr_pkg::OFS_PRE_TRIGGER_COUNT: begin
          if (CB_WDATA[acr_pkg::PRE_W-1:0] < acr_pkg::PRE_MIN) begin
            pre_trigger_count_reg <= acr_pkg::PRE_MIN;
          end else begin
            pre_trigger_count_reg <= CB_WDATA[acr_pkg::PRE_W-1:0];
          end
        end
        default: ;
      endcase
    end
  end

  // The access data register also takes the byte returned by a converter read.
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      converter_access_data_reg <= acr_pkg::RST_ZERO16;
    end else if (cif.rd_done) begin
      converter_access_data_reg[acr_pkg::CAD_DATA_LSB +: acr_pkg::CAD_BYTE_W] <= cif.rdata;
    end else if (CB_WR && CB_ADDR == acr_pkg::OFS_CONV_ACCESS_DATA) begin
      converter_access_data_reg <= CB_WDATA;
    end
  end

  // Converter access start on the rising edge of the go bit.
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      go_prev_reg    <= 1'b0;
      conv_start_reg <= 1'b0;
      CONV_RESET     <= 1'b0;
    end else begin
      go_prev_reg    <= converter_access_control_reg[acr_pkg::CAC_GO_BIT];
      // An edge seen while busy is dropped; software polls the ready flag first.
      conv_start_reg <= converter_access_control_reg[acr_pkg::CAC_GO_BIT] && !go_prev_reg && !cif.busy;
      CONV_RESET     <= converter_access_control_reg[acr_pkg::CAC_RESET_BIT];
    end
  end

  assign cif.start     = conv_start_reg;
  assign cif.all_chips = converter_access_control_reg[acr_pkg::CAC_ALL_BIT];
  assign cif.chip      = converter_access_control_reg[acr_pkg::CAC_CHIP_LSB +: acr_pkg::CH_W];
  assign cif.rnw       = converter_access_control_reg[acr_pkg::CAC_RNW_BIT];
  assign cif.reg_addr  = converter_access_data_reg[acr_pkg::CAD_REG_LSB +: acr_pkg::CAD_BYTE_W];
  assign cif.wdata     = converter_access_data_reg[acr_pkg::CAD_DATA_LSB +: acr_pkg::CAD_BYTE_W];

  acr_conv_seq u_conv_seq (
    .clk        (CLK_SYS),
    .rst        (RESET),
    .conv_ack   (CONV_ACK),
    .conv_rdata (CONV_RDATA),
    .cif        (cif.seq)
  );

  assign CONV_SEL   = cif.conv_sel;
  assign CONV_REQ   = cif.conv_req;
  assign CONV_RNW   = cif.conv_rnw;
  assign CONV_ADDR  = cif.conv_addr;
  assign CONV_WDATA = cif.conv_wdata;

  // Sample source and per-channel zero forcing.
  assign src_samples = processing_config_reg[acr_pkg::CFG_PLAYBACK_BIT] ? PLAYBACK_SAMPLES : LIVE_SAMPLES;

  genvar ch;
  generate
    for (ch = 0; ch < acr_pkg::NUM_CH; ch++) begin : g_mask
      always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
          PROC_SAMPLES[ch*acr_pkg::SMP_W +: acr_pkg::SMP_W] <= 12'h000;
        end else if (channel_zero_mask_reg[ch]) begin
          PROC_SAMPLES[ch*acr_pkg::SMP_W +: acr_pkg::SMP_W] <= 12'h000;
        end else begin
          PROC_SAMPLES[ch*acr_pkg::SMP_W +: acr_pkg::SMP_W] <= src_samples[ch*acr_pkg::SMP_W +: acr_pkg::SMP_W];
        end
      end
    end
  endgenerate

  // Debug monitor follows the selected channel every cycle.
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      debug_monitor_reg <= acr_pkg::RST_ZERO16;
    end else begin
      debug_monitor_reg <= {4'h0, src_samples[mon_sel*acr_pkg::SMP_W +: acr_pkg::SMP_W]};
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      trigger_count_reg <= acr_pkg::RST_ZERO16;
    end else if (TRIGGER) begin
      trigger_count_reg <= trigger_count_reg + 16'h0001;
    end
  end

  // Configuration outputs.
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      PULSE_COUNT       <= 2'h0;
      WINDOW_LENGTH     <= acr_pkg::WIN_MIN;
      REPORT_LENGTH     <= acr_pkg::WIN_MIN;
      DISCARD_LAST      <= 1'b0;
      LOOKBACK_DEPTH    <= 11'h000;
      PRE_TRIGGER_COUNT <= acr_pkg::PRE_MIN;
    end else begin
      PULSE_COUNT       <= processing_config_reg[acr_pkg::CFG_PULSES_LSB +: acr_pkg::CFG_PULSES_W];
      WINDOW_LENGTH     <= window_length_reg;
      // Odd windows are padded to the next even count and the pad sample is flagged for discard.
      REPORT_LENGTH     <= window_length_reg + {8'h00, window_length_reg[0]};
      DISCARD_LAST      <= window_length_reg[0];
      LOOKBACK_DEPTH    <= lookback_depth_reg;
      PRE_TRIGGER_COUNT <= pre_trigger_count_reg;
    end
  end

  // Formatter dispatch: one launch pulse per event for mode codes 0-3, two for the raw-then-timing code, none for codes 4-6.
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      fmt_state_reg <= acr_pkg::FMT_IDLE;
      FMT_START     <= 4'h0;
    end else begin
      FMT_START <= 4'h0;
      case (fmt_state_reg)
        acr_pkg::FMT_IDLE: begin
          if (EVENT_READY && processing_config_reg[acr_pkg::CFG_RUN_BIT]) begin
            fmt_state_reg <= acr_pkg::FMT_LAUNCH;
          end
        end
        acr_pkg::FMT_LAUNCH: begin
          fmt_state_reg <= acr_pkg::FMT_WAIT;
          case (mode)
            acr_pkg::MODE_RAW:            FMT_START[acr_pkg::FMT_RAW_IDX] <= 1'b1;
            acr_pkg::MODE_PULSE:          FMT_START[acr_pkg::FMT_PULSE_IDX] <= 1'b1;
            acr_pkg::MODE_INTEGRAL:       FMT_START[acr_pkg::FMT_INTEGRAL_IDX] <= 1'b1;
            acr_pkg::MODE_TIMING:         FMT_START[acr_pkg::FMT_TIMING_IDX] <= 1'b1;
            acr_pkg::MODE_RAW_THEN_TIMING: FMT_START[acr_pkg::FMT_RAW_IDX] <= 1'b1;
            default:                      fmt_state_reg <= acr_pkg::FMT_IDLE;
          endcase
        end
        acr_pkg::FMT_WAIT: begin
          if (FMT_DONE) begin
            if (mode == acr_pkg::MODE_RAW_THEN_TIMING) begin
              fmt_state_reg <= acr_pkg::FMT_LAUNCH2;
            end else begin
              fmt_state_reg <= acr_pkg::FMT_IDLE;
            end
          end
        end
        acr_pkg::FMT_LAUNCH2: begin
          FMT_START[acr_pkg::FMT_TIMING_IDX] <= 1'b1;
          fmt_state_reg <= acr_pkg::FMT_WAIT2;
        end
        acr_pkg::FMT_WAIT2: begin
          if (FMT_DONE) begin
            fmt_state_reg <= acr_pkg::FMT_IDLE;
          end
        end
        default: fmt_state_reg <= acr_pkg::FMT_IDLE;
      endcase
    end
  end

  // Read multiplexer; answer lands one cycle after the strobe.
  always_comb begin
    rdata_next = acr_pkg::RST_ZERO16;
    case (CB_ADDR)
      acr_pkg::OFS_VERSION_AND_READY:   rdata_next = {!cif.busy && !conv_start_reg, FW_VERSION};
      acr_pkg::OFS_TRIGGER_COUNT:       rdata_next = trigger_count_reg;
      acr_pkg::OFS_DEBUG_MONITOR:       rdata_next = debug_monitor_reg;
      acr_pkg::OFS_PROCESSING_CONFIG:   rdata_next = processing_config_reg;
      acr_pkg::OFS_CHANNEL_ZERO_MASK:   rdata_next = channel_zero_mask_reg;
      acr_pkg::OFS_CONV_ACCESS_CONTROL: rdata_next = converter_access_control_reg;
      acr_pkg::OFS_CONV_ACCESS_DATA:    rdata_next = converter_access_data_reg;
      acr_pkg::OFS_WINDOW_LENGTH:       rdata_next = {7'h00, window_length_reg};
      acr_pkg::OFS_LOOKBACK_DEPTH:      rdata_next = {5'h00, lookback_depth_reg};
      acr_pkg::OFS_PRE_TRIGGER_COUNT:   rdata_next = {4'h0, pre_trigger_count_reg};
      default:                          rdata_next = acr_pkg::RST_ZERO16;
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      CB_RDATA  <= acr_pkg::RST_ZERO16;
      CB_RVALID <= 1'b0;
    end else begin
      CB_RVALID <= CB_RD;
      if (CB_RD) begin
        CB_RDATA <= rdata_next;
      end
    end
  end
endmodule : acr_register_bank
`default_nettype wire

// [acr_tb.sv]
// Self-checking bench for the control-bus register bank.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic         clk_sys, reset, cb_wr, cb_rd, cb_rvalid, trigger, event_ready, fmt_done;
  logic         conv_ack, conv_req, conv_rnw, conv_reset, discard_last;
  logic [15:0]  cb_addr, cb_wdata, cb_rdata, conv_sel, rd_val;
  logic [191:0] live, play, proc_s;
  logic [3:0]   fmt_start, dly;
  logic [7:0]   conv_addr, conv_wdata, conv_rdata;
  logic [8:0]   win_len, rep_len;
  logic [10:0]  look;
  logic [11:0]  pre;
  logic [1:0]   pulse_count;
  int           fails, n_compared;
  localparam logic [15:0] RV [11] = '{16'h8123, 16'h0000, 16'h0A00, 16'h0000, 16'h0000, 16'h0000,
                                      16'h0000, 16'h0006, 16'h0000, 16'h0002, 16'h0000};

  acr_register_bank #(.FW_VERSION(15'h0123)) DUT (
    .CLK_SYS(clk_sys), .RESET(reset), .CB_ADDR(cb_addr), .CB_WR(cb_wr), .CB_RD(cb_rd), .CB_WDATA(cb_wdata),
    .CB_RDATA(cb_rdata), .CB_RVALID(cb_rvalid), .LIVE_SAMPLES(live), .PLAYBACK_SAMPLES(play),
    .PROC_SAMPLES(proc_s), .TRIGGER(trigger), .EVENT_READY(event_ready), .FMT_DONE(fmt_done),
    .FMT_START(fmt_start), .PULSE_COUNT(pulse_count), .WINDOW_LENGTH(win_len), .REPORT_LENGTH(rep_len),
    .DISCARD_LAST(discard_last), .LOOKBACK_DEPTH(look), .PRE_TRIGGER_COUNT(pre), .CONV_RESET(conv_reset),
    .CONV_SEL(conv_sel), .CONV_REQ(conv_req), .CONV_RNW(conv_rnw), .CONV_ADDR(conv_addr),
    .CONV_WDATA(conv_wdata), .CONV_ACK(conv_ack), .CONV_RDATA(conv_rdata));
  acr_conv_model u_conv (.clk(clk_sys), .rst(reset), .req(conv_req), .rnw(conv_rnw), .addr(conv_addr),
    .dly(dly), .ack(conv_ack), .rdata(conv_rdata));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_sys) #1;
    cb_addr = a;
    cb_wdata = d;
    cb_wr = 1'b1;
    @(posedge clk_sys) #1;
    cb_wr = 1'b0;
  endtask
  task automatic rd(input logic [15:0] a);
    @(posedge clk_sys) #1;
    cb_addr = a;
    cb_rd = 1'b1;
    @(posedge clk_sys) #1;
    cb_rd = 1'b0;
    chk("rvalid", 16'h0001, {15'h0000, cb_rvalid});
    rd_val = cb_rdata;
  endtask
  task automatic rdc(input logic [15:0] a, input logic [15:0] exp);
    rd(a);
    chk($sformatf("reg %h", a), exp, rd_val);
  endtask
  task automatic close_out;
    $display("compared %0d failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Launch one event and collect up to two formatter starts; a zero expectation means the window must stay empty.
  task automatic fmt_run(input logic [2:0] m, input logic [3:0] e1, input logic [3:0] e2);
    int i;
    logic [3:0] seen;
    wr(16'h0003, {12'h000, 1'b1, m});
    event_ready = 1'b1;
    seen = 4'h0;
    for (i = 0; i < 8 && seen == 4'h0; i++) begin
      @(posedge clk_sys) #1;
      seen = fmt_start;
    end
    event_ready = 1'b0;
    chk("fmt first", {12'h000, e1}, {12'h000, seen});
    if (e1 != 4'h0) chk("fmt latency", 16'h0002, 16'(i));
    fmt_done = 1'b1;
    @(posedge clk_sys) #1;
    fmt_done = 1'b0;
    seen = 4'h0;
    for (i = 0; i < 8 && seen == 4'h0; i++) begin
      @(posedge clk_sys) #1;
      seen = fmt_start;
    end
    chk("fmt second", {12'h000, e2}, {12'h000, seen});
    fmt_done = 1'b1;
    @(posedge clk_sys) #1;
    fmt_done = 1'b0;
  endtask
  task automatic conv(input logic [15:0] dat, input logic [7:0] ctl, input logic [15:0] sel, input logic [3:0] d);
    int i;
    dly = d;
    wr(16'h0006, dat);
    wr(16'h0005, {8'h00, ctl});
    wr(16'h0005, {8'h00, ctl | 8'h80});
    repeat (2) @(posedge clk_sys) #1;
    chk("conv req", 16'h0001, {15'h0000, conv_req});
    chk("conv sel", sel, conv_sel);
    chk("conv fields", {dat[15:8], dat[7:0]}, {conv_addr, conv_wdata});
    chk("conv rnw", {15'h0000, ctl[5]}, {15'h0000, conv_rnw});
    rdc(16'h0000, 16'h0123);
    for (i = 0; i < 30 && !rd_val[15]; i++) rd(16'h0000);
    chk("ready", 16'h8123, rd_val);
    chk("sel idle", 16'h0000, conv_sel);
  endtask

  initial begin
    reset = 1'b1;
    {cb_wr, cb_rd, trigger, event_ready, fmt_done} = 5'h00;
    cb_addr = 16'h0000;
    cb_wdata = 16'h0000;
    dly = 4'h0;
    fails = 0;
    n_compared = 0;
    for (int n = 0; n < 16; n++) begin
      live[12*n +: 12] = 12'hA00 + 12'(n);
      play[12*n +: 12] = 12'h500 + 12'(n);
    end
    repeat (6) @(posedge clk_sys);
    #1;
    reset = 1'b0;
    for (int a = 0; a < 11; a++) rdc(16'(a), RV[a]);
    wr(16'h0000, 16'h0000);
    wr(16'h000C, 16'hFFFF);
    rdc(16'h0000, 16'h8123);
    rdc(16'h000C, 16'h0000);
    wr(16'h0007, 16'h0007);
    rdc(16'h0007, 16'h0007);
    chk("report len", 16'h0008, {7'h00, rep_len});
    chk("discard", 16'h0001, {15'h0000, discard_last});
    wr(16'h0007, 16'h0005);
    rdc(16'h0007, 16'h0006);
    wr(16'h0008, 16'h07FF);
    rdc(16'h0008, 16'h07FF);
    chk("lookback", 16'h07FF, {5'h00, look});
    wr(16'h0009, 16'h0ABC);
    rdc(16'h0009, 16'h0ABC);
    wr(16'h0009, 16'h0001);
    rdc(16'h0009, 16'h0002);
    chk("pretrig", 16'h0002, {4'h0, pre});
    wr(16'h0004, 16'h8001);
    wr(16'h0003, 16'h0530);
    rdc(16'h0002, 16'h0A05);
    chk("pulses", 16'h0003, {14'h0000, pulse_count});
    chk("ch0", 16'h0000, {4'h0, proc_s[11:0]});
    chk("ch15", 16'h0000, {4'h0, proc_s[191:180]});
    chk("ch1", 16'h0A01, {4'h0, proc_s[23:12]});
    wr(16'h0003, 16'h0580);
    rdc(16'h0002, 16'h0505);
    chk("ch1 play", 16'h0501, {4'h0, proc_s[23:12]});
    wr(16'h0004, 16'h0000);
    repeat (3) begin
      @(posedge clk_sys) #1;
      trigger = 1'b1;
      @(posedge clk_sys) #1;
      trigger = 1'b0;
    end
    rdc(16'h0001, 16'h0003);
    fmt_run(3'h0, 4'h1, 4'h0);
    fmt_run(3'h1, 4'h2, 4'h0);
    fmt_run(3'h2, 4'h4, 4'h0);
    fmt_run(3'h3, 4'h8, 4'h0);
    fmt_run(3'h7, 4'h1, 4'h8);
    fmt_run(3'h4, 4'h0, 4'h0);
    conv(16'h3C5A, 8'h03, 16'h0008, 4'h8);
    conv(16'h4100, 8'h60, 16'hFFFF, 4'h0);
    rdc(16'h0006, 16'h41BE);
    wr(16'h0005, 16'h0010);
    @(posedge clk_sys) #1;
    chk("conv reset", 16'h0001, {15'h0000, conv_reset});
    close_out;
  end
endmodule // testbench
`default_nettype wire
